// ### verilog/jtag_cfg_pkg.sv
// Constants and types for the JTAG configuration port
package jtag_cfg_pkg;

    localparam int IR_W       = 4;
    localparam int WORD_W     = 8;
    localparam int FIFO_DEPTH = 32;
    localparam int TLR_EDGES  = 5;
    localparam int DIV_HALF   = 2;

    localparam logic [IR_W-1:0] IR_BYPASS  = 4'hf;
    localparam logic [IR_W-1:0] IR_CFG     = 4'h2;
    localparam logic [IR_W-1:0] IR_STATUS  = 4'h3;
    localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;

    localparam logic [2:0] MODE_AS = 3'h2;

    // Pins driven by the host into the port
    typedef struct packed {
        logic tdi;
        logic tms;
    } jtag_in_type;

    typedef enum logic [15:0] {
        TLR    = 16'h0001,
        RTI    = 16'h0002,
        SEL_DR = 16'h0004,
        CAP_DR = 16'h0008,
        SH_DR  = 16'h0010,
        EX1_DR = 16'h0020,
        PA_DR  = 16'h0040,
        EX2_DR = 16'h0080,
        UPD_DR = 16'h0100,
        SEL_IR = 16'h0200,
        CAP_IR = 16'h0400,
        SH_IR  = 16'h0800,
        EX1_IR = 16'h1000,
        PA_IR  = 16'h2000,
        EX2_IR = 16'h4000,
        UPD_IR = 16'h8000
    } tap_state_type;

endpackage : jtag_cfg_pkg

// ### verilog/jtag_config_port.sv
// JTAG configuration port with its word FIFO
`timescale 1ns/10ps

// Synchronous FIFO with valid/ready on both sides
module cfg_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 32
) (
    input  wire logic         i_ref_clk,
    input  wire logic         i_srst,
    input  wire logic         i_clk_en,
    input  wire logic         i_valid,
    output logic              o_ready,
    input  wire logic [W-1:0] i_data,
    output logic              o_valid,
    input  wire logic         i_ready,
    output logic [W-1:0]      o_data,
    output logic              o_full,
    output logic              o_empty
);
    localparam int AW = $clog2(DEPTH);

    // Pointer wrap logic only works for power-of-two depths
    if (DEPTH != (1 << AW) || DEPTH < 2) begin : g_bad_depth
        $error("cfg_fifo depth must be a power of two");
    end

    logic [W-1:0] mem [DEPTH];
    logic [AW:0]  wr_r;
    logic [AW:0]  rd_r;
    wire          push = i_valid && !o_full && i_clk_en;
    wire          pop  = i_ready && !o_empty && i_clk_en;

    // Full when pointers differ only in the wrap bit
    assign o_full  = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
    assign o_empty = (wr_r == rd_r);
    assign o_ready = !o_full;
    assign o_valid = !o_empty;
    assign o_data  = mem[rd_r[AW-1:0]];

    // Pointer update
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            wr_r <= '0;
            rd_r <= '0;
        end else begin
            if (push)
                wr_r <= wr_r + 1'b1;
            if (pop)
                rd_r <= rd_r + 1'b1;
        end
    end

    // Storage write
    always_ff @(posedge i_ref_clk) begin
        if (push)
            mem[wr_r[AW-1:0]] <= i_data;
    end
endmodule : cfg_fifo

module jtag_config_port #(
    parameter int WORD_BITS = jtag_cfg_pkg::WORD_W,
    parameter int DEPTH     = jtag_cfg_pkg::FIFO_DEPTH
) (
    input  wire logic                     i_ref_clk,
    input  wire logic                     i_srst,
    input  wire logic                     i_clk_en,
    input  wire logic                     i_tck,
    input  wire jtag_cfg_pkg::jtag_in_type i_jtag,
    output logic                          o_tdo,
    output logic                          o_tdo_oe,
    input  wire logic [2:0]               i_mode_select_pins,
    input  wire logic                     i_ps_busy,
    input  wire logic                     i_cfg_ready,
    output logic                          o_cfg_valid,
    output logic [WORD_BITS-1:0]          o_cfg_data,
    output logic                          o_ps_abort,
    output logic                          o_other_cfg_hold,
    output logic                          o_user_io_hiz,
    output logic                          o_config_clock_out,
    output logic                          o_config_clock_oe,
    output logic                          o_config_complete_flag,
    output logic                          o_overrun
);
    import jtag_cfg_pkg::*;

    localparam int BW = $clog2(WORD_BITS);

    // Bit counter wraps cleanly only for power-of-two word widths
    if (WORD_BITS < 2 || WORD_BITS != (1 << BW)) begin : g_bad_width
        $error("WORD_BITS must be a power of two, at least 2");
    end

    // Standard TAP transition
    function automatic tap_state_type tap_next(tap_state_type s, logic m);
        tap_state_type n;
        n = TLR;
        unique case (s)
            TLR:     n = m ? TLR    : RTI;
            RTI:     n = m ? SEL_DR : RTI;
            SEL_DR:  n = m ? SEL_IR : CAP_DR;
            CAP_DR:  n = m ? EX1_DR : SH_DR;
            SH_DR:   n = m ? EX1_DR : SH_DR;
            EX1_DR:  n = m ? UPD_DR : PA_DR;
            PA_DR:   n = m ? EX2_DR : PA_DR;
            EX2_DR:  n = m ? UPD_DR : SH_DR;
            UPD_DR:  n = m ? SEL_DR : RTI;
            SEL_IR:  n = m ? TLR    : CAP_IR;
            CAP_IR:  n = m ? EX1_IR : SH_IR;
            SH_IR:   n = m ? EX1_IR : SH_IR;
            EX1_IR:  n = m ? UPD_IR : PA_IR;
            PA_IR:   n = m ? EX2_IR : PA_IR;
            EX2_IR:  n = m ? UPD_IR : SH_IR;
            UPD_IR:  n = m ? SEL_DR : RTI;
            default: n = TLR;
        endcase
        return n;
    endfunction : tap_next

    // ---------------- TCK domain ----------------
    logic                 trst_s1_r;
    logic                 tck_rst;
    logic                 done_s1_r;
    logic                 done_tck_r;
    tap_state_type        tap_r;
    logic [IR_W-1:0]      ir_sh_r;
    logic [IR_W-1:0]      ir_r;
    logic                 byp_r;
    logic                 stat_r;
    logic [WORD_BITS-1:0] word_sh_r;
    logic [BW-1:0]        bit_cnt_r;
    logic [WORD_BITS-1:0] word_r;
    logic                 word_tgl_r;
    logic                 done_tgl_r;
    logic                 cfg_act_r;
    logic [2:0]           tms_cnt_r;

    wire tdi = i_jtag.tdi;
    wire tms = i_jtag.tms;
    wire sh_dr = (tap_r == SH_DR);
    wire sh_ir = (tap_r == SH_IR);
    wire word_end = sh_dr && (ir_r == IR_CFG)
                    && (bit_cnt_r == BW'(WORD_BITS - 1));
    wire [WORD_BITS-1:0] word_nxt = {tdi, word_sh_r[WORD_BITS-1:1]};
    wire load_ir = (tap_r == UPD_IR);

    // Reset and complete flag brought into the TCK domain
    always_ff @(posedge i_tck) begin
        trst_s1_r  <= i_srst;
        tck_rst    <= trst_s1_r;
        done_s1_r  <= o_config_complete_flag;
        done_tck_r <= done_s1_r;
    end

    // TAP controller and instruction register
    always_ff @(posedge i_tck) begin
        if (tck_rst) begin
            tap_r   <= TLR;
            ir_sh_r <= '0;
            ir_r    <= IR_BYPASS;
        end else begin
            tap_r <= tap_next(tap_r, tms);
            if (tap_r == TLR)
                ir_r <= IR_BYPASS;
            else if (load_ir)
                ir_r <= ir_sh_r;
            if (tap_r == CAP_IR)
                ir_sh_r <= IR_CAPTURE;
            else if (sh_ir)
                ir_sh_r <= {tdi, ir_sh_r[IR_W-1:1]};
        end
    end

    // Data registers: bypass, status and configuration word
    always_ff @(posedge i_tck) begin
        if (tck_rst) begin
            byp_r     <= 1'b0;
            stat_r    <= 1'b0;
            word_sh_r <= '0;
            bit_cnt_r <= '0;
        end else if (tap_r == CAP_DR) begin
            byp_r     <= 1'b0;
            stat_r    <= done_tck_r;
            bit_cnt_r <= '0;
        end else if (sh_dr) begin
            byp_r     <= tdi;
            stat_r    <= tdi;
            word_sh_r <= word_nxt;
            bit_cnt_r <= bit_cnt_r + 1'b1;
        end
    end

    // Word hand-off and configuration activity
    always_ff @(posedge i_tck) begin
        if (tck_rst) begin
            word_r     <= '0;
            word_tgl_r <= 1'b0;
            done_tgl_r <= 1'b0;
            cfg_act_r  <= 1'b0;
        end else begin
            if (word_end) begin
                word_r     <= word_nxt;
                word_tgl_r <= !word_tgl_r;
            end
            if (tap_r == UPD_DR && ir_r == IR_CFG)
                done_tgl_r <= !done_tgl_r;
            if (tap_r == TLR)
                cfg_act_r <= 1'b0;
            else if (load_ir)
                cfg_act_r <= (ir_sh_r == IR_CFG);
        end
    end

    // TDO source selection
    wire dr_out = (ir_r == IR_BYPASS) ? byp_r :
                  (ir_r == IR_STATUS) ? stat_r : word_sh_r[0];
    wire tdo_nxt = sh_ir ? ir_sh_r[0] : dr_out;

    // Output stage on the falling edge
    always_ff @(negedge i_tck) begin
        if (tck_rst) begin
            o_tdo    <= 1'b0;
            o_tdo_oe <= 1'b0;
        end else begin
            o_tdo    <= tdo_nxt;
            o_tdo_oe <= sh_ir || sh_dr;
        end
    end

    // Run of TMS-high edges, watched by the reset check
    always_ff @(posedge i_tck) begin
        if (tck_rst || !tms)
            tms_cnt_r <= '0;
        else if (tms_cnt_r != 3'(TLR_EDGES))
            tms_cnt_r <= tms_cnt_r + 1'b1;
    end

    // TCK-domain checks
    sequence byp_shift;
        sh_dr && ir_r == IR_BYPASS;
    endsequence

    a_tap_step: assert property (@(posedge i_tck) disable iff (tck_rst)
        sh_dr |=> tap_r == ($past(tms) ? EX1_DR : SH_DR))
        else $error("TAP left data shift wrongly");
    a_tlr_after_five: assert property (@(posedge i_tck)
        disable iff (tck_rst)
        tms_cnt_r == 3'(TLR_EDGES) |-> tap_r == TLR)
        else $error("TAP not in reset after five TMS highs");
    a_tdo_idle_hiz: assert property (@(posedge i_tck) disable iff (tck_rst)
        !sh_ir && !sh_dr ##1 !sh_ir && !sh_dr |-> !o_tdo_oe)
        else $error("TDO driven while not shifting");
    a_bypass_delay: assert property (@(posedge i_tck) disable iff (tck_rst)
        byp_shift ##1 byp_shift |-> o_tdo == $past(tdi))
        else $error("Bypass output not one cycle late");
    a_word_handoff: assert property (@(posedge i_tck) disable iff (tck_rst)
        word_end |=> word_tgl_r != $past(word_tgl_r)
                     && word_r[WORD_BITS-1] == $past(tdi))
        else $error("Configuration word not handed off");
    a_cfg_start: assert property (@(posedge i_tck) disable iff (tck_rst)
        load_ir && ir_sh_r == IR_CFG
        |=> cfg_act_r && ir_r == IR_CFG)
        else $error("Configuration instruction not taken");

    // ---------------- Reference clock domain ----------------
    logic [2:0]           mode_s1_r;
    logic [2:0]           mode_r;
    logic                 act_s1_r;
    logic                 act_r;
    logic                 act_d_r;
    logic [2:0]           wtgl_r;
    logic [2:0]           dtgl_r;
    logic                 pend_r;
    logic [WORD_BITS-1:0] pend_data_r;
    logic                 done_pend_r;
    logic [1:0]           div_r;
    logic                 fifo_ready;
    logic                 fifo_empty;

    wire as_mode    = (mode_r == MODE_AS);
    wire word_seen  = wtgl_r[1] ^ wtgl_r[2];
    wire done_seen  = dtgl_r[1] ^ dtgl_r[2];
    wire cfg_start  = act_r && !act_d_r;
    wire push_ok    = pend_r && fifo_ready;
    wire finish     = done_pend_r && fifo_empty && !pend_r && !o_overrun;
    wire config_clock_out_run   = as_mode && !act_r;

    // Pin and cross-domain synchronisers
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            mode_s1_r <= '0;
            mode_r    <= '0;
            act_s1_r  <= 1'b0;
            act_r     <= 1'b0;
            act_d_r   <= 1'b0;
            wtgl_r    <= '0;
            dtgl_r    <= '0;
        end else if (i_clk_en) begin
            mode_s1_r <= i_mode_select_pins;
            mode_r    <= mode_s1_r;
            act_s1_r  <= cfg_act_r;
            act_r     <= act_s1_r;
            act_d_r   <= act_r;
            wtgl_r    <= {wtgl_r[1:0], word_tgl_r};
            dtgl_r    <= {dtgl_r[1:0], done_tgl_r};
        end
    end

    // Holding stage in front of the FIFO; word_r is steady for a word time
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            pend_r      <= 1'b0;
            pend_data_r <= '0;
            o_overrun   <= 1'b0;
        end else if (i_clk_en) begin
            if (word_seen && (!pend_r || push_ok)) begin
                pend_r      <= 1'b1;
                pend_data_r <= word_r;
            end else if (push_ok) begin
                pend_r <= 1'b0;
            end
            if (word_seen && pend_r && !fifo_ready)
                o_overrun <= 1'b1;
            else if (cfg_start)
                o_overrun <= 1'b0;
        end
    end

    cfg_fifo #(
        .W     (WORD_BITS),
        .DEPTH (DEPTH)
    ) u_fifo (
        .i_ref_clk (i_ref_clk),
        .i_srst    (i_srst),
        .i_clk_en  (i_clk_en),
        .i_valid   (pend_r),
        .o_ready   (fifo_ready),
        .i_data    (pend_data_r),
        .o_valid   (o_cfg_valid),
        .i_ready   (i_cfg_ready),
        .o_data    (o_cfg_data),
        .o_full    (),
        .o_empty   (fifo_empty)
    );

    // Mode arbitration and completion flag
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_ps_abort             <= 1'b0;
            o_other_cfg_hold       <= 1'b0;
            o_user_io_hiz          <= 1'b0;
            done_pend_r            <= 1'b0;
            o_config_complete_flag <= 1'b0;
        end else if (i_clk_en) begin
            o_other_cfg_hold <= act_r;
            o_ps_abort       <= act_r && i_ps_busy;
            o_user_io_hiz    <= act_r;
            if (done_seen)
                done_pend_r <= 1'b1;
            else if (finish || cfg_start)
                done_pend_r <= 1'b0;
            if (finish)
                o_config_complete_flag <= 1'b1;
            else if (cfg_start)
                o_config_complete_flag <= 1'b0;
        end
    end

    // Config clock divider, silent while JTAG owns the device
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            div_r              <= '0;
            o_config_clock_out <= 1'b0;
            o_config_clock_oe  <= 1'b0;
        end else if (i_clk_en) begin
            o_config_clock_oe <= config_clock_out_run;
            if (!config_clock_out_run) begin
                div_r              <= '0;
                o_config_clock_out <= 1'b0;
            end else if (div_r == 2'(DIV_HALF - 1)) begin
                div_r              <= '0;
                o_config_clock_out <= !o_config_clock_out;
            end else begin
                div_r <= div_r + 1'b1;
            end
        end
    end

    // Reference-domain checks
    sequence jtag_owns;
        i_clk_en && act_r;
    endsequence

    a_other_held: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        jtag_owns |=> o_other_cfg_hold)
        else $error("Other modes not held off");
    a_ps_abort: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        jtag_owns ##0 i_ps_busy |=> o_ps_abort)
        else $error("Passive serial load not aborted");
    a_config_clock_out_quiet: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        jtag_owns ##1 i_clk_en && act_r |=> !o_config_clock_oe
                                           && !o_config_clock_out)
        else $error("Config clock driven during JTAG load");
    a_user_io_hiz: assert property (@(posedge i_ref_clk)
        disable iff (i_srst)
        jtag_owns |=> o_user_io_hiz)
        else $error("User I/O not tri-stated");
    a_done_flag: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        i_clk_en && finish |=> o_config_complete_flag)
        else $error("Complete flag not raised");
endmodule : jtag_config_port

// ### dv/jtag_host.sv
// Behavioural JTAG host that drives the test port pins
`timescale 1ns/10ps

module jtag_host
    import jtag_cfg_pkg::*;
#(
    parameter int HALF = 15
) (
    output logic      o_tck,
    output logic      o_tms,
    output logic      o_tdi,
    input  wire logic i_tdo,
    input  wire logic i_tdo_oe
);

    // Clock stands still between frames, pins rest at pulled-up levels
    initial begin
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tdi = 1'b1;
    end

    // One TCK period: pins set while low, TDO taken just before the rise
    task automatic step(input logic m, input logic d, output logic q,
                        output logic e);
        o_tms = m;
        o_tdi = d;
        #(HALF);
        // A released TDO reads as the inverse of its last value
        q = i_tdo_oe ? i_tdo : !i_tdo;
        e = i_tdo_oe;
        o_tck = 1'b1;
        #(HALF);
        o_tck = 1'b0;
    endtask : step

    // Five TMS-high edges, then park in run-test/idle
    task automatic reset_tap();
        logic q, e;
        repeat (TLR_EDGES) step(1'b1, 1'b1, q, e);
        step(1'b0, 1'b1, q, e);
        o_tms = 1'b1;
    endtask : reset_tap

    // Walks idle to a shift state, shifts n bits LSB first, back to idle
    task automatic shift(input logic ir, input logic [511:0] d,
                         input int n, output logic [511:0] q,
                         output logic [511:0] e);
        logic x, y;
        step(1'b1, 1'b1, x, y);
        if (ir) step(1'b1, 1'b1, x, y);
        step(1'b0, 1'b1, x, y);
        step(1'b0, 1'b1, x, y);
        for (int k = 0; k < n; k++) begin
            step(k == n - 1, d[k], q[k], e[k]);
        end
        step(1'b1, 1'b1, x, y);
        step(1'b0, 1'b1, x, y);
        o_tms = 1'b1;
        o_tdi = 1'b1;
    endtask : shift

endmodule : jtag_host

// ### dv/test_jtag_config_port.sv
// Self-checking bench for the JTAG configuration port
`timescale 1ns/10ps

module test_jtag_config_port;
    import jtag_cfg_pkg::*;

    logic              i_ref_clk, i_srst, i_clk_en, tck, tms, tdi;
    wire jtag_in_type  i_jtag = {tdi, tms};
    logic [2:0]        i_mode_select_pins;
    logic              i_ps_busy, i_cfg_ready, drain, a;
    logic              o_tdo, o_tdo_oe, o_cfg_valid, o_ps_abort;
    logic              o_other_cfg_hold, o_user_io_hiz, o_overrun;
    logic              o_config_clock_out, o_config_clock_oe;
    logic              o_config_complete_flag;
    logic [WORD_W-1:0] o_cfg_data;
    logic [WORD_W-1:0] exp_q[$];
    logic [511:0]      din, dout, doe;
    int                errors, cmp_count, seed, cycles;

    jtag_config_port #(.WORD_BITS(WORD_W), .DEPTH(FIFO_DEPTH)) uut (
        .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_clk_en(i_clk_en),
        .i_tck(tck), .i_jtag(i_jtag), .o_tdo(o_tdo),
        .o_tdo_oe(o_tdo_oe), .i_mode_select_pins(i_mode_select_pins),
        .i_ps_busy(i_ps_busy), .i_cfg_ready(i_cfg_ready),
        .o_cfg_valid(o_cfg_valid), .o_cfg_data(o_cfg_data),
        .o_ps_abort(o_ps_abort), .o_other_cfg_hold(o_other_cfg_hold),
        .o_user_io_hiz(o_user_io_hiz),
        .o_config_clock_out(o_config_clock_out),
        .o_config_clock_oe(o_config_clock_oe),
        .o_config_complete_flag(o_config_complete_flag),
        .o_overrun(o_overrun));

    jtag_host host (.o_tck(tck), .o_tms(tms), .o_tdi(tdi),
                    .i_tdo(o_tdo), .i_tdo_oe(o_tdo_oe));

    // Reference clock, 50 ns period
    initial begin
        i_ref_clk = 1'b0;
        forever #25 i_ref_clk = ~i_ref_clk;
    end

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test

    // Hang guard
    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == 30000) begin
            errors++;
            finish_test();
        end
    end

    // Consumer stalls and freezes at random while draining
    always @(negedge i_ref_clk) begin
        i_cfg_ready <= drain && ($random(seed) & 1);
        i_clk_en <= !drain || (($random(seed) & 3) != 0);
    end

    // Popped words must match the shifted words in order
    always @(posedge i_ref_clk) begin
        if (o_cfg_valid === 1'b1 && i_cfg_ready && i_clk_en) begin
            check("cfg_data", o_cfg_data,
                  exp_q.size() != 0 ? exp_q.pop_front() : 'x);
        end
    end

    // Config clock may only run in active serial mode with JTAG idle
    function automatic logic exp_clk_oe(input logic act,
                                        input logic [2:0] mode);
        return (mode == MODE_AS) && !act;
    endfunction : exp_clk_oe

    // Arbitration outputs follow the config instruction being active
    task automatic arb(input logic act);
        repeat (6) @(negedge i_ref_clk);
        check("hold", o_other_cfg_hold, act);
        check("ps_abort", o_ps_abort, act & i_ps_busy);
        check("io_hiz", o_user_io_hiz, act);
        check("clk_oe", o_config_clock_oe,
              exp_clk_oe(act, i_mode_select_pins));
        check("tdo_idle", o_tdo_oe, 1'b0);
    endtask : arb

    // Streams nw random words, the first keep of them expected back
    task automatic stream(input int nw, input int keep);
        din = '0;
        for (int w = 0; w < nw; w++) begin
            din[w*WORD_W +: WORD_W] = WORD_W'($random(seed));
            if (w < keep) exp_q.push_back(din[w*WORD_W +: WORD_W]);
        end
        host.shift(1'b0, din, nw * WORD_W, dout, doe);
        repeat (10) @(negedge i_ref_clk);
    endtask : stream

    task automatic drain_all();
        drain = 1'b1;
        for (int i = 0; i < 600 && exp_q.size() != 0; i++) begin
            @(negedge i_ref_clk);
        end
        repeat (8) @(negedge i_ref_clk);
        drain = 1'b0;
        check("cfg_valid", o_cfg_valid, 1'b0);
    endtask : drain_all

    task automatic status(input logic exp);
        host.shift(1'b1, IR_STATUS, IR_W, dout, doe);
        host.shift(1'b0, '0, 1, dout, doe);
        check("status", dout[0], exp);
    endtask : status

    initial begin
        errors = 0;
        cmp_count = 0;
        seed = 61;
        cycles = 0;
        drain = 1'b0;
        i_srst = 1'b1;
        i_ps_busy = 1'b0;
        i_mode_select_pins = 3'h0;
        // TCK must run while reset is held so the TCK side sees it
        fork
            host.reset_tap();
            repeat (5) @(negedge i_ref_clk);
        join
        i_srst = 1'b0;
        host.reset_tap();
        check("complete", o_config_complete_flag, 1'b0);
        for (int m = 0; m < 8; m++) begin
            @(negedge i_ref_clk);
            i_mode_select_pins = m[2:0];
            repeat (6) @(negedge i_ref_clk);
            check("clk_oe", o_config_clock_oe,
                  exp_clk_oe(1'b0, m[2:0]));
        end
        i_mode_select_pins = MODE_AS;
        repeat (6) @(negedge i_ref_clk);
        a = o_config_clock_out;
        repeat (DIV_HALF) @(negedge i_ref_clk);
        check("clk_out", o_config_clock_out, !a);
        $display("done: reset and mode pins");
        host.shift(1'b1, IR_BYPASS, IR_W, dout, doe);
        check("ir_capture", dout[IR_W-1:0], IR_CAPTURE);
        din = {$random(seed), $random(seed)};
        host.shift(1'b0, din, 40, dout, doe);
        for (int k = 1; k < 40; k++) begin
            check("bypass_tdo", dout[k], din[k-1]);
            check("tdo_oe", doe[k], 1'b1);
        end
        arb(1'b0);
        $display("done: bypass");
        @(negedge i_ref_clk);
        i_ps_busy = 1'b1;
        host.shift(1'b1, IR_CFG, IR_W, dout, doe);
        arb(1'b1);
        stream(FIFO_DEPTH + 2, FIFO_DEPTH + 1);
        check("overrun", o_overrun, 1'b1);
        arb(1'b1);
        drain_all();
        check("complete", o_config_complete_flag, 1'b0);
        status(1'b0);
        arb(1'b0);
        $display("done: abort and overrun");
        @(negedge i_ref_clk);
        i_ps_busy = 1'b0;
        host.shift(1'b1, IR_CFG, IR_W, dout, doe);
        arb(1'b1);
        check("overrun", o_overrun, 1'b0);
        stream(3, 3);
        drain_all();
        check("complete", o_config_complete_flag, 1'b1);
        status(1'b1);
        $display("done: clean load");
        host.shift(1'b1, IR_CFG, IR_W, dout, doe);
        arb(1'b1);
        check("complete", o_config_complete_flag, 1'b0);
        host.reset_tap();
        arb(1'b0);
        $display("done: tap reset");
        finish_test();
    end

endmodule : test_jtag_config_port
